// ==== arf_analog_model.sv ====
// Purpose: Behavioural analog side: input multiplexer, reference and sensor.
// Assumes: The bench starts one conversion at a time.
// Notes:   Idle raw lines toggle every cycle so a stale value never passes.
`timescale 1ns/1ps
`default_nettype none
module arf_analog_model (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire arf_pkg::arf_front_t front,
	input  wire logic                start,
	input  wire logic                slow,
	input  wire logic signed [15:0]  level,
	output arf_pkg::arf_sample_t     sample
);
	// ==========================================================================
	// Conversion
	logic [3:0]         wait_q;
	logic               busy_q;
	logic signed [15:0] held_q;

	// Latch the level at start, then answer one cycle after it, or eight cycles after it when slow.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_q <= 1'b0;
			wait_q <= 4'h0;
			held_q <= 16'h0000;
			sample <= '0;
		end else begin
			sample.done <= 1'b0;
			sample.raw  <= ~sample.raw;
			if (start && !busy_q) begin
				busy_q <= 1'b1;
				wait_q <= slow ? 4'h7 : 4'h0;
				// A sensor reading is only meaningful on the internal reference.
				held_q <= (front.sensor_enable && !front.internal_ref_on) ? ~level : level;
			end else if (busy_q && wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end else if (busy_q) begin
				busy_q      <= 1'b0;
				sample.done <= 1'b1;
				sample.raw  <= held_q;
			end
		end
	end
endmodule
`default_nettype wire

// ==== arf_consts.svh ====
// Purpose: Register offsets, field positions, codes and limits of the result formatter.
// Assumes: Included by the design module and the bench by bare name.
// Notes:   Definitions only; every offset is a byte address on a 32-bit bus.
`ifndef ARF_CONSTS_SVH
`define ARF_CONSTS_SVH

// ==========================================================================
// Register map
`define ARF_OFF_MUX      8'h00
`define ARF_OFF_CTRL_B   8'h04
`define ARF_OFF_RES_LO   8'h08
`define ARF_OFF_RES_HI   8'h0C
`define ARF_OFF_STATUS   8'h10
`define ARF_OFF_MASK     8'h14

// ==========================================================================
// Fields and reset values
`define ARF_MUX_RESET    8'h00
`define ARF_REF_MSB      7
`define ARF_REF_LSB      6
`define ARF_CHAN_MSB     5
`define ARF_BIP_BIT      0
`define ARF_ST_DONE      0
`define ARF_ST_CLAMP     1
`define ARF_EVT_W        2
`define ARF_RES_HI_W     2

// ==========================================================================
// Channel and reference codes
`define ARF_CHAN_TEMP    6'h22
`define ARF_CHAN_SE_HI   3'h4
`define ARF_CHAN_SE_TOP  3'h2
`define ARF_REF_SUPPLY   2'h0
`define ARF_REF_EXT      2'h1
`define ARF_REF_INT      2'h2

// ==========================================================================
// Code limits
`define ARF_UNI_MAX      10'h3FF
`define ARF_UNI_MIN      10'h000
`define ARF_BIP_MAX      10'h1FF
`define ARF_BIP_MIN      10'h200
`define ARF_BIP_MAX_I    511
`define ARF_BIP_MIN_I    (-512)
`define ARF_UNI_MAX_I    1023

// ==========================================================================
// Bus answers
`define ARF_RESP_OKAY    2'h0
`define ARF_RESP_SLVERR  2'h2

`endif

// ==== arf_pkg.sv ====
// Purpose: Types shared by the result formatter and its bench.
// Assumes: arf_consts.svh holds the numbers.
// Notes:   Types only.
`default_nettype none
package arf_pkg;

	// Conversion class, one-hot.
	typedef enum logic [2:0] {
		ARF_SINGLE  = 3'b001,
		ARF_UNIPOL  = 3'b010,
		ARF_BIPOL   = 3'b100
	} arf_class_t;

	// Finished conversion from the analog side, at unity gain, 1024/Vref scale.
	typedef struct packed {
		logic               done;
		logic signed [15:0] raw;
	} arf_sample_t;

	// Selection presented to multiplexer, reference and sensor.
	typedef struct packed {
		logic [1:0] reference_select;
		logic [5:0] channel_select;
		logic       differential;
		logic       gain_x20;
		logic       sensor_enable;
		logic       internal_ref_on;
	} arf_front_t;

endpackage
`default_nettype wire

// ==== arf_result_fmt.sv ====
// Purpose: Formats finished conversions into result bytes, selects channel and reference.
// Assumes: AXI4-Lite slave on aclk; sample.done is a one-cycle pulse.
// Notes:   Reading the low byte freezes the high byte for the next high read.
`timescale 1ns/1ps
`default_nettype none
`include "arf_consts.svh"

// What this block does (R1-R10, R14-R16) and what software must do (R11-R13)
// R1: Finished result stays in the two result bytes until the next completion.
// R2: Single-ended results are unsigned codes 0x000 to 0x3FF, saturated.
// R3: Unipolar differential results are unsigned codes from 0x000 to 0x3FF.
// R4: Unipolar differential clamps to zero when negative input exceeds positive.
// R5: Bipolar differential uses half scale, two's complement 0x200 to 0x1FF.
// R6: In bipolar mode result bit nine is the sign, one meaning negative.
// R7: Reset gives unipolar mode; writing one to bipolar select enables bipolar.
// R8: In bipolar mode a negative difference is encoded, not clamped.
// R9: Differential conversions apply gain 1x or 20x from the channel code.
// R10: Channel code 100010 picks the temperature channel and powers the sensor.
// R11: Software picks the internal 1.1V reference for temperature readings.
// R12: Software runs temperature readings as single, individually started conversions.
// R13: Digital port outputs should not toggle while a conversion runs.
// R14: Result bytes and completion flag are written in the same cycle.
// R15: Reference code 10 is internal, 00 the supply, 01 the external pin.
// R16: The two result bytes read back from one and the same conversion.
module arf_result_fmt #(
	parameter int ADDR_W = 8,
	parameter int RAW_W  = 16
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire arf_pkg::arf_sample_t sample,
	output arf_pkg::arf_front_t     front,
	output logic                    irq
);

	localparam int GW = 22;

	// ======================================================================
	// Parameter checks
	generate
		if (ADDR_W < 5 || ADDR_W > 32 || RAW_W != 16) begin : g_bad_param
			$error("arf_result_fmt: unsupported ADDR_W or RAW_W");
		end
	endgenerate

	localparam logic signed [GW-1:0] UNI_MAX = GW'(`ARF_UNI_MAX_I);
	localparam logic signed [GW-1:0] BIP_MAX = GW'(`ARF_BIP_MAX_I);
	localparam logic signed [GW-1:0] BIP_MIN = GW'(`ARF_BIP_MIN_I);

	logic [7:0]              mux_q;
	logic                    bip_q;
	logic [9:0]              result_q;
	logic [`ARF_RES_HI_W-1:0] hi_shadow_q;
	logic [`ARF_EVT_W-1:0]   status_q;
	logic [`ARF_EVT_W-1:0]   mask_q;
	arf_pkg::arf_front_t     front_q;
	logic [ADDR_W-1:0]       awaddr_q;
	logic                    aw_held_q;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic                    w_held_q;
	logic [31:0]             rdata_q;
	logic [1:0]              rresp_q;
	logic                    rvalid_q;
	logic [1:0]              bresp_q;
	logic                    bvalid_q;
	logic                    wr_fire;
	logic                    rd_fire;
	logic [7:0]              wr_off;
	logic [7:0]              rd_off;
	arf_pkg::arf_class_t     cls;
	logic                    diff_sel;
	logic signed [GW-1:0]    ext;
	logic signed [GW-1:0]    gained;
	logic signed [GW-1:0]    half;
	logic [9:0]              code_d;
	logic                    clamp_d;

	// ======================================================================
	// Write channel: address and data taken in either order, answered together.
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
	assign wr_off        = 8'(awaddr_q);
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	// Holds the write address until the data has also arrived.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	// Holds the write data until the address has also arrived.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	// Write response, error for an unmapped offset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `ARF_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			unique case (wr_off)
				`ARF_OFF_MUX, `ARF_OFF_CTRL_B, `ARF_OFF_RES_LO, `ARF_OFF_RES_HI,
				`ARF_OFF_STATUS, `ARF_OFF_MASK: bresp_q <= `ARF_RESP_OKAY;
				default: bresp_q <= `ARF_RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Control registers; only byte lane zero carries data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mux_q  <= `ARF_MUX_RESET;
			bip_q  <= 1'b0; // R7
			mask_q <= '0;
		end else if (wr_fire && wstrb_q[0]) begin
			if (wr_off == `ARF_OFF_MUX) begin
				mux_q <= wdata_q[7:0];
			end
			if (wr_off == `ARF_OFF_CTRL_B) begin
				bip_q <= wdata_q[`ARF_BIP_BIT]; // R7
			end
			if (wr_off == `ARF_OFF_MASK) begin
				mask_q <= wdata_q[`ARF_EVT_W-1:0];
			end
		end
	end

	// ======================================================================
	// Front-end selection, registered from the multiplexer register.
	always_comb begin
		diff_sel = !(mux_q[`ARF_CHAN_MSB:3] == 3'h0) &&
			!(mux_q[`ARF_CHAN_MSB:3] == `ARF_CHAN_SE_HI && mux_q[2:0] <= `ARF_CHAN_SE_TOP);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			front_q <= '0;
		end else begin
			front_q.reference_select <= mux_q[`ARF_REF_MSB:`ARF_REF_LSB];
			front_q.channel_select   <= mux_q[`ARF_CHAN_MSB:0];
			front_q.differential     <= diff_sel;
			front_q.gain_x20         <= diff_sel && mux_q[0]; // R9
			front_q.sensor_enable    <= mux_q[`ARF_CHAN_MSB:0] == `ARF_CHAN_TEMP; // R10
			front_q.internal_ref_on  <= mux_q[`ARF_REF_MSB:`ARF_REF_LSB] == `ARF_REF_INT; // R15
		end
	end
	assign front = front_q;

	// ======================================================================
	// Result coding: gain, scale, saturation and sign.
	always_comb begin
		cls     = !front_q.differential ? arf_pkg::ARF_SINGLE :
			(bip_q ? arf_pkg::ARF_BIPOL : arf_pkg::ARF_UNIPOL);
		ext     = GW'(sample.raw);
		gained  = front_q.gain_x20 ? (ext <<< 4) + (ext <<< 2) : ext; // R9
		half    = gained >>> 1; // R5
		code_d  = `ARF_UNI_MIN;
		clamp_d = 1'b0;
		unique case (cls)
			arf_pkg::ARF_SINGLE, arf_pkg::ARF_UNIPOL: begin
				if (gained < 0) begin
					code_d  = `ARF_UNI_MIN; // R4
					clamp_d = 1'b1;
				end else if (gained > UNI_MAX) begin
					code_d  = `ARF_UNI_MAX; // R2 R3
					clamp_d = 1'b1;
				end else begin
					code_d = gained[9:0]; // R2 R3
				end
			end
			arf_pkg::ARF_BIPOL: begin
				if (half < BIP_MIN) begin
					code_d  = `ARF_BIP_MIN; // R5 R6
					clamp_d = 1'b1;
				end else if (half > BIP_MAX) begin
					code_d  = `ARF_BIP_MAX; // R5
					clamp_d = 1'b1;
				end else begin
					code_d = half[9:0]; // R8 R6
				end
			end
		endcase
	end

	// Result is written only on completion and held otherwise.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_q <= `ARF_UNI_MIN;
		end else if (sample.done) begin
			result_q <= code_d; // R1 R14
		end
	end

	// Status flags: hardware set wins over a write-one clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~((wr_fire && wstrb_q[0] && wr_off == `ARF_OFF_STATUS) ?
				wdata_q[`ARF_EVT_W-1:0] : '0))
				| {sample.done && clamp_d, sample.done}; // R14
		end
	end
	assign irq = |(status_q & mask_q);

	// ======================================================================
	// Read channel: one cycle from address to data.
	assign s_axi_arready = !rvalid_q;
	assign rd_fire       = s_axi_arvalid && !rvalid_q;
	assign rd_off        = 8'(s_axi_araddr);
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `ARF_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rresp_q  <= `ARF_RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
			unique case (rd_off)
				`ARF_OFF_MUX:    rdata_q[7:0] <= mux_q;
				`ARF_OFF_CTRL_B: rdata_q[`ARF_BIP_BIT] <= bip_q;
				`ARF_OFF_RES_LO: rdata_q[7:0] <= result_q[7:0];
				`ARF_OFF_RES_HI: rdata_q[`ARF_RES_HI_W-1:0] <= hi_shadow_q; // R16
				`ARF_OFF_STATUS: rdata_q[`ARF_EVT_W-1:0] <= status_q;
				`ARF_OFF_MASK:   rdata_q[`ARF_EVT_W-1:0] <= mask_q;
				default:         rresp_q <= `ARF_RESP_SLVERR;
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Low-byte read freezes the matching high byte so both come from one result.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_shadow_q <= '0;
		end else if (rd_fire && rd_off == `ARF_OFF_RES_LO) begin
			hi_shadow_q <= result_q[9:8]; // R16
		end
	end

	// ======================================================================
	// Checks
	a_hold_result: assert property (@(posedge aclk) disable iff (!aresetn) // R1
		!sample.done |=> $stable(result_q)) else $error("result changed without completion");
	a_single_range: assert property (@(posedge aclk) disable iff (!aresetn) // R2
		sample.done && !front_q.differential && sample.raw > 16'sd1023 |=> result_q == `ARF_UNI_MAX)
		else $error("single-ended overrange not saturated");
	a_uni_pass: assert property (@(posedge aclk) disable iff (!aresetn) // R3
		sample.done && front_q.differential && !front_q.gain_x20 && !bip_q
		&& sample.raw == 16'sd700 |=> result_q == 10'd700) else $error("unipolar code wrong");
	a_uni_clamp: assert property (@(posedge aclk) disable iff (!aresetn) // R4
		sample.done && front_q.differential && !bip_q && sample.raw < 0
		|=> result_q == `ARF_UNI_MIN ##0 status_q[`ARF_ST_CLAMP])
		else $error("unipolar negative not clamped");
	a_bip_sign: assert property (@(posedge aclk) disable iff (!aresetn) // R6
		sample.done && front_q.differential && bip_q
		|=> result_q[9] == $past(sample.raw[15]) || result_q == `ARF_UNI_MIN)
		else $error("bipolar sign bit wrong");
	a_bip_neg: assert property (@(posedge aclk) disable iff (!aresetn) // R8
		sample.done && front_q.differential && !front_q.gain_x20 && bip_q
		&& sample.raw == -16'sd4 |=> result_q == 10'h3FE) else $error("bipolar negative not encoded");
	a_reset_mode: assert property (@(posedge aclk) // R7
		!aresetn |=> !bip_q) else $error("reset did not give unipolar mode");
	a_gain_x20: assert property (@(posedge aclk) disable iff (!aresetn) // R9
		sample.done && front_q.gain_x20 && !bip_q && sample.raw == 16'sd3 |=> result_q == 10'd60)
		else $error("gain of twenty not applied");
	a_temp_sensor: assert property (@(posedge aclk) disable iff (!aresetn) // R10
		mux_q[`ARF_CHAN_MSB:0] == `ARF_CHAN_TEMP |=> front_q.sensor_enable && !front_q.differential)
		else $error("temperature channel not enabled");
	a_done_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R14
		sample.done |=> status_q[`ARF_ST_DONE] && result_q == $past(code_d))
		else $error("flag and result not written together");
	a_ref_internal: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		mux_q[`ARF_REF_MSB:`ARF_REF_LSB] == `ARF_REF_INT |=> front_q.internal_ref_on)
		else $error("internal reference not selected");
	a_byte_pair: assert property (@(posedge aclk) disable iff (!aresetn) // R16
		rd_fire && rd_off == `ARF_OFF_RES_LO |=> hi_shadow_q == $past(result_q[9:8]))
		else $error("high byte not frozen with low byte");
	c_bipolar_done: cover property (@(posedge aclk) disable iff (!aresetn)
		sample.done && bip_q && front_q.differential);
	c_temp_read: cover property (@(posedge aclk) disable iff (!aresetn)
		sample.done && front_q.sensor_enable);
	c_irq_raise: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));

endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the result formatter.
// Assumes: Partner model supplies conversions; registers over AXI4-Lite.
// Notes:   Reset, unmapped and interrupt checks first, then corner cases, seeded random conversions, then sensor and coherence checks.
`timescale 1ns/1ps
`default_nettype none
`include "arf_consts.svh"
module testbench;
	// ==========================================================================
	// Signals
	logic                 aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic                 awready, wready, bvalid, arready, rvalid, irq, start, slow;
	logic [7:0]           awaddr, araddr;
	logic [31:0]          wdata, rdata, d, lo;
	logic [3:0]           wstrb;
	logic [1:0]           bresp, rresp, r;
	logic signed [15:0]   level;
	arf_pkg::arf_sample_t sample;
	arf_pkg::arf_front_t  front;
	int                   miscompares, n_tests, seed, i;
	logic [5:0]           cch[11] = '{6'h03, 6'h03, 6'h08, 6'h09, 6'h08, 6'h08, 6'h09, 6'h28,
		6'h08, 6'h09, 6'h08};
	logic [5:0]           rch[5] = '{6'h03, 6'h08, 6'h09, 6'h22, 6'h28};
	int                   craw[11] = '{0, 1024, -40, 60, -1030, 1023, -7, -1, 700, 3, -4};
	logic [10:0]          cbip = 11'b100_1111_0000;

	arf_result_fmt dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sample(sample), .front(front), .irq(irq));
	arf_analog_model partner (.aclk(aclk), .aresetn(aresetn), .front(front),
		.start(start), .slow(slow), .level(level), .sample(sample));

	// Clock generation.
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// ==========================================================================
	// Helpers
	// Compare, count and report.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Print the totals and the verdict, then stop.
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One AXI4-Lite write; channels are released as each is taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int k;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		rs = bresp;
		chk(32'(k < 50), 32'h0000_0001);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	// One AXI4-Lite read.
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int k;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		v = rdata;
		rs = rresp;
		chk(32'(k < 50), 32'h0000_0001);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// Start one conversion of the given level and wait for its completion.
	task automatic convert(input int raw);
		int k;
		start <= 1'b1;
		level <= 16'(raw);
		slow <= 1'($urandom_range(1));
		@(posedge aclk);
		start <= 1'b0;
		for (k = 0; k < 20 && sample.done !== 1'b1; k++) @(posedge aclk);
		chk(32'(k < 20), 32'h0000_0001);
		@(posedge aclk);
	endtask

	// Expected ten-bit code for a channel code, mode and unity-gain level.
	function automatic logic [9:0] exp_code(input logic [5:0] ch, input logic bip, input int raw);
		int  v;
		logic diff;
		diff = (ch[5:3] != 3'h0) && !(ch inside {[6'h20:6'h22]});
		v = (diff && ch[0]) ? raw * 20 : raw;
		if (diff && bip) begin
			v = v >>> 1;
			v = (v > 511) ? 511 : ((v < -512) ? -512 : v);
		end else begin
			v = (v > 1023) ? 1023 : ((v < 0) ? 0 : v);
		end
		return v[9:0];
	endfunction

	// Select channel on the internal reference, set the mode, convert, read both bytes.
	task automatic run_one(input logic [5:0] ch, input logic bip, input int raw);
		wr(`ARF_OFF_MUX, {24'h0000_00, `ARF_REF_INT, ch}, r);
		wr(`ARF_OFF_CTRL_B, {31'h0000_0000, bip}, r);
		convert(raw);
		rd(`ARF_OFF_RES_LO, lo, r);
		rd(`ARF_OFF_RES_HI, d, r);
		chk(32'({d[1:0], lo[7:0]}), 32'(exp_code(ch, bip, raw)));
		chk(32'(r), 32'(`ARF_RESP_OKAY));
	endtask

	// ==========================================================================
	// Tests
	// Main sequence.
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, start, slow} = 8'h00;
		{awaddr, araddr, wdata, level} = '0;
		wstrb = 4'h1;
		seed = $urandom(68385);
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 6; i++) begin
			rd(8'(4 * i), d, r);
			chk(d, 32'h0000_0000);
		end
		wr(8'h18, 32'h0000_0001, r);
		chk(32'(r), 32'(`ARF_RESP_SLVERR));
		rd(8'h18, d, r);
		chk(d, 32'h0000_0000);
		chk(32'(r), 32'(`ARF_RESP_SLVERR));
		$display("test reset and unmapped done");
		wr(`ARF_OFF_MUX, 32'h0000_0088, r);
		wr(`ARF_OFF_MASK, 32'h0000_0001, r);
		convert(-20);
		chk(32'(irq), 32'h0000_0001);
		rd(`ARF_OFF_RES_LO, d, r);
		chk(d, 32'h0000_0000);
		rd(`ARF_OFF_STATUS, d, r);
		chk(d, 32'h0000_0003);
		wr(`ARF_OFF_MASK, 32'h0000_0000, r);
		chk(32'(irq), 32'h0000_0000);
		wr(`ARF_OFF_MASK, 32'h0000_0001, r);
		chk(32'(irq), 32'h0000_0001);
		wr(`ARF_OFF_STATUS, 32'h0000_0003, r);
		chk(32'(irq), 32'h0000_0000);
		// A write with byte lane zero disabled must leave the register alone.
		wstrb <= 4'h0;
		wr(`ARF_OFF_MUX, 32'h0000_00FF, r);
		wstrb <= 4'h1;
		chk(32'(r), 32'(`ARF_RESP_OKAY));
		rd(`ARF_OFF_MUX, d, r);
		chk(d, 32'h0000_0088);
		$display("test interrupt done");
		for (i = 0; i < 11; i++) run_one(cch[i], cbip[i], craw[i]);
		for (i = 0; i < 40; i++) run_one(rch[$urandom_range(4)], 1'($urandom_range(1)),
			int'($urandom_range(2400)) - 1200);
		$display("test conversions done");
		for (i = 0; i < 3; i++) begin
			wr(`ARF_OFF_MUX, {24'h0000_00, 2'(i), `ARF_CHAN_TEMP}, r);
			chk(32'({front.sensor_enable, front.internal_ref_on, front.reference_select,
				front.channel_select, front.differential, front.gain_x20}),
				32'({1'b1, i == 2, 2'(i), `ARF_CHAN_TEMP, 2'b00}));
		end
		$display("test sensor and reference done");
		run_one(6'h03, 1'b0, 768);
		rd(`ARF_OFF_RES_LO, lo, r);
		convert(80);
		rd(`ARF_OFF_RES_HI, d, r);
		chk(d, 32'h0000_0003);
		$display("test coherence done");
		give_verdict;
	end

	// Watchdog against a hung handshake.
	initial begin
		#300000;
		miscompares++;
		give_verdict;
	end
endmodule
`default_nettype wire
